/* File: logic/prsg_pkg.sv */
// Package for the peripheral reset, sleep gating and PWM clock divider block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package prsg_pkg;
   localparam int unsigned NUM_PERIPH = 16;
   localparam int unsigned NUM_PINS   = 24;

   // Register byte offsets.
   localparam logic [7:0] ADDR_RUN_EN    = 8'h00;
   localparam logic [7:0] ADDR_SLEEP_EN  = 8'h04;
   localparam logic [7:0] ADDR_GATE_CTL  = 8'h08;
   localparam logic [7:0] ADDR_SW_RESET  = 8'h0c;
   localparam logic [7:0] ADDR_PWM_DIV   = 8'h10;
   localparam logic [7:0] ADDR_PIN_PRES  = 8'h14;
   localparam logic [7:0] ADDR_READY     = 8'h18;

   // Reset values.
   localparam logic [15:0] RUN_EN_RST   = 16'h0000;
   localparam logic [15:0] SLEEP_EN_RST = 16'h0000;
   localparam logic [2:0]  PWM_DIV_RST  = 3'h0;

   // Cycle counts.
   localparam logic [2:0] SW_RST_CYCLES = 3'h4;
   localparam logic [2:0] ENABLE_CYCLES = 3'h5;

   // PWM divide codes 1 to 6 give a ratio of two to the power of the code; code 0 holds PWM_CLK high.
   typedef enum logic [2:0] {
      pwm_clk_div_by_one       = 3'h0,
      pwm_clk_div_by_two       = 3'h1,
      pwm_clk_div_by_four      = 3'h2,
      pwm_clk_div_by_eight     = 3'h3,
      pwm_clk_div_by_sixteen   = 3'h4,
      pwm_clk_div_by_thirtytwo = 3'h5,
      pwm_clk_div_by_sixtyfour = 3'h6
   } prsg_div_t;

   // Per-peripheral gating outputs travel together.
   typedef struct packed {
      logic [15:0] clk_en;
      logic [15:0] rst;
      logic [15:0] ready;
   } prsg_periph_t;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/prsg_top.sv */
// Peripheral run enables, software reset pulses, sleep-mode clock gating,
// PWM clock divider and pin presence, reached over AXI4-Lite.
// Assumes all inputs synchronous to REF_CLK and a synchronous reset.
`timescale 1ns/10ps

// Contract
// - Software reset pulses one peripheral's reset line
// - Sleep-disabled peripheral clock stops during sleep
// - Run-enabled peripheral resumes after sleep, state kept
// - Sleep-enabled peripheral keeps clock during sleep
// - Sleep enables act only with global gating
// - PWM clock is processor clock over 2^n (code 0 holds PWM_CLK high instead)
// - Selected PWM divide ratio reads back
// - PWM clock follows current system clock
// - Read-only presence bit for each optional pin
// - Five cycles after enable, accesses bus-fault
// - Run enables clear at reset; disabled peripheral inert
module prsg_top #(
   parameter int unsigned          NP           = prsg_pkg::NUM_PERIPH,
   parameter logic [23:0]          PIN_PRESENT  = 24'hffffff
) (
   input  wire logic               REF_CLK,
   input  wire logic               SRST,
   input  wire logic               CPU_SLEEP,
   input  wire logic [7:0]         S_AXI_AWADDR,
   input  wire logic               S_AXI_AWVALID,
   output logic                    S_AXI_AWREADY,
   input  wire logic [31:0]        S_AXI_WDATA,
   input  wire logic [3:0]         S_AXI_WSTRB,
   input  wire logic               S_AXI_WVALID,
   output logic                    S_AXI_WREADY,
   output logic [1:0]              S_AXI_BRESP,
   output logic                    S_AXI_BVALID,
   input  wire logic               S_AXI_BREADY,
   input  wire logic [7:0]         S_AXI_ARADDR,
   input  wire logic               S_AXI_ARVALID,
   output logic                    S_AXI_ARREADY,
   output logic [31:0]             S_AXI_RDATA,
   output logic [1:0]              S_AXI_RRESP,
   output logic                    S_AXI_RVALID,
   input  wire logic               S_AXI_RREADY,
   output prsg_pkg::prsg_periph_t  PERIPH,
   output logic                    PWM_CLK
);

   logic [15:0] run_en_reg, run_en_next;
   logic [15:0] sleep_en_reg, sleep_en_next;
   logic        gate_en_reg, gate_en_next;
   logic [2:0]  div_reg, div_next;
   logic [15:0] rst_req_reg, rst_req_next;
   logic [2:0]  rst_cnt_reg [NP];
   logic [2:0]  rst_cnt_next [NP];
   logic [2:0]  en_cnt_reg [NP];
   logic [2:0]  en_cnt_next [NP];
   logic [5:0]  pwm_cnt_reg, pwm_cnt_next;
   logic        pwm_clk_reg, pwm_clk_next;
   prsg_pkg::prsg_periph_t periph_reg, periph_next;

   logic        aw_ok_reg, aw_ok_next;
   logic        w_ok_reg, w_ok_next;
   logic [7:0]  aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0]  w_strb_reg, w_strb_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wr_fire;
   logic        rd_fire;
   logic        awready_reg, awready_next;
   logic        wready_reg, wready_next;
   logic        arready_reg, arready_next;

   // Returns one when the byte address names a mapped register.
   function automatic logic addr_mapped(input logic [7:0] a);
      if (a == prsg_pkg::ADDR_RUN_EN || a == prsg_pkg::ADDR_SLEEP_EN ||
          a == prsg_pkg::ADDR_GATE_CTL || a == prsg_pkg::ADDR_SW_RESET ||
          a == prsg_pkg::ADDR_PWM_DIV || a == prsg_pkg::ADDR_PIN_PRES ||
          a == prsg_pkg::ADDR_READY) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   // Applies the two low byte lanes of a write to a 16-bit register image.
   function automatic logic [15:0] merge_lanes(input logic [15:0] cur, input logic [31:0] d,
                                               input logic [3:0] s);
      logic [15:0] r;
      r = cur;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Write channels are taken independently and held until both are in.
   assign wr_fire = aw_ok_reg && w_ok_reg && !bvalid_reg;
   assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb begin
      aw_ok_next   = aw_ok_reg;
      w_ok_next    = w_ok_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (S_AXI_AWVALID && !aw_ok_reg) begin
         aw_ok_next   = 1'b1;
         aw_addr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_ok_reg) begin
         w_ok_next   = 1'b1;
         w_data_next = S_AXI_WDATA;
         w_strb_next = S_AXI_WSTRB;
      end
      if (wr_fire) begin
         aw_ok_next  = 1'b0;
         w_ok_next   = 1'b0;
         bvalid_next = 1'b1;
         bresp_next  = addr_mapped(aw_addr_reg) ? prsg_pkg::RESP_OKAY : prsg_pkg::RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      // Readies are registered copies so that every port leaves a flop.
      awready_next = !aw_ok_next;
      wready_next  = !w_ok_next;
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rresp_next  = prsg_pkg::RESP_OKAY;
         rdata_next  = 32'h0;
         if (S_AXI_ARADDR == prsg_pkg::ADDR_RUN_EN) begin
            rdata_next = {16'h0, run_en_reg};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_SLEEP_EN) begin
            rdata_next = {16'h0, sleep_en_reg};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_GATE_CTL) begin
            rdata_next = {31'h0, gate_en_reg};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_SW_RESET) begin
            rdata_next = {16'h0, rst_req_reg};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_PWM_DIV) begin
            rdata_next = {29'h0, div_reg};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_PIN_PRES) begin
            rdata_next = {8'h0, PIN_PRESENT};
         end else if (S_AXI_ARADDR == prsg_pkg::ADDR_READY) begin
            rdata_next = {16'h0, periph_reg.ready};
         end else begin
            rresp_next = prsg_pkg::RESP_SLVERR;
         end
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      arready_next = !rvalid_next;
   end

   // Register writes. Lane 0 and 1 carry the 16 per-peripheral bits.
   always_comb begin
      run_en_next   = run_en_reg;
      sleep_en_next = sleep_en_reg;
      gate_en_next  = gate_en_reg;
      div_next      = div_reg;
      rst_req_next  = rst_req_reg;
      for (int i = 0; i < NP; i++) begin
         if (rst_req_reg[i] && rst_cnt_reg[i] == 3'h1) begin
            rst_req_next[i] = 1'b0;
         end
      end
      if (wr_fire) begin
         if (aw_addr_reg == prsg_pkg::ADDR_RUN_EN) begin
            run_en_next = merge_lanes(run_en_reg, w_data_reg, w_strb_reg);
         end else if (aw_addr_reg == prsg_pkg::ADDR_SLEEP_EN) begin
            sleep_en_next = merge_lanes(sleep_en_reg, w_data_reg, w_strb_reg);
         end else if (aw_addr_reg == prsg_pkg::ADDR_GATE_CTL) begin
            if (w_strb_reg[0]) gate_en_next = w_data_reg[0];
         end else if (aw_addr_reg == prsg_pkg::ADDR_SW_RESET) begin
            // New requests are ORed in; a request in flight is never dropped.
            rst_req_next = rst_req_next | merge_lanes(16'h0000, w_data_reg, w_strb_reg);
         end else if (aw_addr_reg == prsg_pkg::ADDR_PWM_DIV) begin
            // Codes beyond divide-by-64 are ignored so the readback stays legal.
            if (w_strb_reg[0] && w_data_reg[2:0] <= 3'(prsg_pkg::pwm_clk_div_by_sixtyfour)) begin
               div_next = w_data_reg[2:0];
            end
         end
      end
   end

   // Per-peripheral reset pulse, enable settle count and clock gate.
   always_comb begin
      periph_next = periph_reg;
      for (int i = 0; i < NP; i++) begin
         rst_cnt_next[i] = rst_cnt_reg[i];
         en_cnt_next[i]  = en_cnt_reg[i];
         // A request landing as the last pulse cycle ends restarts it, so it is never lost.
         if (rst_req_next[i] && (!rst_req_reg[i] || rst_cnt_reg[i] == 3'h1)) begin
            rst_cnt_next[i] = prsg_pkg::SW_RST_CYCLES;
         end else if (rst_cnt_reg[i] != 3'h0) begin
            rst_cnt_next[i] = rst_cnt_reg[i] - 3'h1;
         end
         periph_next.rst[i] = (rst_cnt_next[i] != 3'h0);
         // Counting starts on the edge after the enable lands, so ready rises five edges later.
         if (!run_en_reg[i] || !run_en_next[i]) begin
            en_cnt_next[i] = prsg_pkg::ENABLE_CYCLES;
         end else if (en_cnt_reg[i] != 3'h0) begin
            en_cnt_next[i] = en_cnt_reg[i] - 3'h1;
         end
         // Ready low makes the peripheral fabric answer accesses with a bus fault.
         periph_next.ready[i] = run_en_next[i] && en_cnt_next[i] == 3'h0;
         // The gate only drops the clock; peripheral state is untouched.
         periph_next.clk_en[i] = run_en_next[i] &&
            !(CPU_SLEEP && gate_en_reg && !sleep_en_reg[i]);
      end
   end

   // The divider counts the live system clock, so its rate follows it.
   always_comb begin
      pwm_cnt_next = pwm_cnt_reg + 6'h1;
      pwm_clk_next = pwm_clk_reg;
      if (div_reg == 3'(prsg_pkg::pwm_clk_div_by_one)) begin
         pwm_clk_next = 1'b1;
      end else begin
         pwm_clk_next = pwm_cnt_next[div_reg - 3'h1];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         run_en_reg   <= prsg_pkg::RUN_EN_RST;
         sleep_en_reg <= prsg_pkg::SLEEP_EN_RST;
         gate_en_reg  <= 1'b0;
         div_reg      <= prsg_pkg::PWM_DIV_RST;
         rst_req_reg  <= 16'h0;
         pwm_cnt_reg  <= 6'h0;
         pwm_clk_reg  <= 1'b0;
         periph_reg   <= '0;
         aw_ok_reg    <= 1'b0;
         w_ok_reg     <= 1'b0;
         aw_addr_reg  <= 8'h0;
         w_data_reg   <= 32'h0;
         w_strb_reg   <= 4'h0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= 2'h0;
         rvalid_reg   <= 1'b0;
         rresp_reg    <= 2'h0;
         rdata_reg    <= 32'h0;
         awready_reg  <= 1'b1;
         wready_reg   <= 1'b1;
         arready_reg  <= 1'b1;
         for (int i = 0; i < NP; i++) begin
            rst_cnt_reg[i] <= 3'h0;
            en_cnt_reg[i]  <= prsg_pkg::ENABLE_CYCLES;
         end
      end else begin
         run_en_reg   <= run_en_next;
         sleep_en_reg <= sleep_en_next;
         gate_en_reg  <= gate_en_next;
         div_reg      <= div_next;
         rst_req_reg  <= rst_req_next;
         pwm_cnt_reg  <= pwm_cnt_next;
         pwm_clk_reg  <= pwm_clk_next;
         periph_reg   <= periph_next;
         aw_ok_reg    <= aw_ok_next;
         w_ok_reg     <= w_ok_next;
         aw_addr_reg  <= aw_addr_next;
         w_data_reg   <= w_data_next;
         w_strb_reg   <= w_strb_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         rvalid_reg   <= rvalid_next;
         rresp_reg    <= rresp_next;
         rdata_reg    <= rdata_next;
         awready_reg  <= awready_next;
         wready_reg   <= wready_next;
         arready_reg  <= arready_next;
         for (int i = 0; i < NP; i++) begin
            rst_cnt_reg[i] <= rst_cnt_next[i];
            en_cnt_reg[i]  <= en_cnt_next[i];
         end
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY  = wready_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign PERIPH        = periph_reg;
   assign PWM_CLK       = pwm_clk_reg;

endmodule

/* File: tb/prsg_monitor.sv */
// Checker for the bus handshake, the reset pulse and the settle timing of prsg_top.
// Assumes binding to prsg_top and sees only its ports.
`timescale 1ns/10ps
module prsg_monitor (
   input wire logic                   REF_CLK,
   input wire logic                   SRST,
   input wire logic                   CPU_SLEEP,
   input wire logic                   S_AXI_AWVALID,
   input wire logic                   S_AXI_AWREADY,
   input wire logic                   S_AXI_WVALID,
   input wire logic                   S_AXI_WREADY,
   input wire logic                   S_AXI_BVALID,
   input wire logic                   S_AXI_BREADY,
   input wire logic                   S_AXI_ARVALID,
   input wire logic                   S_AXI_ARREADY,
   input wire logic [31:0]            S_AXI_RDATA,
   input wire logic                   S_AXI_RVALID,
   input wire logic                   S_AXI_RREADY,
   input wire prsg_pkg::prsg_periph_t PERIPH
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write response missing");
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   a_aw_blocked: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("second write address accepted before response");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response missing");
   a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read response changed");
   a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read accepted during response");
   a_rst_pulse: assert property ($rose(|PERIPH.rst) |-> (|PERIPH.rst) [*4] ##1 !(|PERIPH.rst))
      else $error("reset pulse length wrong");
   // A bit that just became ready must have been low for the four cycles before.
   a_ready_settle: assert property ((PERIPH.ready & ~$past(PERIPH.ready) & ($past(PERIPH.ready, 2) | $past(PERIPH.ready, 3) | $past(PERIPH.ready, 4))) == 16'h0000)
      else $error("peripheral ready too early");
   a_ready_clocked: assert property (!$past(CPU_SLEEP) |-> (PERIPH.ready & ~PERIPH.clk_en) == 16'h0000)
      else $error("ready peripheral not clocked");
endmodule
bind prsg_top prsg_monitor mon_u (.REF_CLK(REF_CLK), .SRST(SRST), .CPU_SLEEP(CPU_SLEEP),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PERIPH(PERIPH));

/* File: tb/prsg_periph_model.sv */
// Peripheral stand-in: a counter that advances only on its gated clock.
// Assumes the clock enable, reset and ready levels of one peripheral.
`timescale 1ns/10ps
module prsg_periph_model (
   input  wire logic       clk,
   input  wire logic       clk_en,
   input  wire logic       rst,
   input  wire logic       ready,
   output logic [7:0]      count
);
   // Counting waits for ready, as software must not touch an unsettled peripheral.
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 8'h00;
      end else if (clk_en && ready) begin
         count <= count + 8'h01;
      end
   end
endmodule

/* File: tb/test_periph_reset_sleep_gating_pwm_clkdiv.sv */
// Self-checking bench for prsg_top with random bus stalls and a peripheral stand-in.
// Assumes the package, the design, the checker and the stand-in are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_periph_reset_sleep_gating_pwm_clkdiv;
   localparam logic [23:0] PINS = 24'ha5c3e1;
   localparam logic [1:0]  OK   = prsg_pkg::RESP_OKAY;
   logic                   clk = 1'b0, srst = 1'b1, sleep = 1'b0;
   logic                   awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [7:0]             awaddr = 8'h00, araddr = 8'h00, cnt, pre;
   logic [31:0]            wdata = 32'h0, rdata;
   logic [1:0]             bresp, rresp;
   logic                   awrdy, wrdy, bvalid, arrdy, rvalid, pwm, prev;
   prsg_pkg::prsg_periph_t per;
   int                     fails = 0, checked = 0, cyc = 0, seed = 25, rst_cnt = 0;
   prsg_top #(.PIN_PRESENT(PINS)) dut_u (.REF_CLK(clk), .SRST(srst), .CPU_SLEEP(sleep),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .PERIPH(per), .PWM_CLK(pwm));
   prsg_periph_model pm_u (.clk(clk), .clk_en(per.clk_en[3]), .rst(per.rst[3]), .ready(per.ready[3]), .count(cnt));
   initial forever #2.5 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Ready lines stall at random so that slow masters are exercised too.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      forever begin
         @(posedge clk);
         if (awrdy) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         if (bvalid && bready) break;
         if (!bready) bready <= 1'($random(seed));
      end
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      forever begin
         @(posedge clk);
         if (arrdy) arv <= 1'b0;
         if (rvalid && rready) break;
         if (!rready) rready <= 1'($random(seed));
      end
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask
   function automatic int pwm_rises(input int c);
      return (c == 0) ? 0 : (128 >> c);
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (per.rst[3] === 1'b1) rst_cnt++;
      if (cyc == 6000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      logic [15:0] v;
      int          hi, rises, c;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      `CHK(per, 48'h0)
      rd(prsg_pkg::ADDR_RUN_EN, 32'h0, OK);
      rd(prsg_pkg::ADDR_SLEEP_EN, 32'h0, OK);
      rd(prsg_pkg::ADDR_READY, 32'h0, OK);
      rd(prsg_pkg::ADDR_PIN_PRES, {8'h00, PINS}, OK);
      rd(8'h1c, 32'h0, prsg_pkg::RESP_SLVERR);
      wr(8'h1c, 32'h1, prsg_pkg::RESP_SLVERR);
      $display("reset test done");
      v = 16'($random(seed)) | 16'h0008;
      wr(prsg_pkg::ADDR_RUN_EN, {16'h0, v}, OK);
      tick(6);
      `CHK(per.ready, v)
      `CHK(per.clk_en, v)
      rd(prsg_pkg::ADDR_READY, {16'h0, v}, OK);
      $display("enable test done");
      tick(20);
      pre = cnt;
      wr(prsg_pkg::ADDR_SW_RESET, 32'h8, OK);
      tick(6);
      `CHK(rst_cnt, 4)
      `CHK(cnt < pre && cnt > 8'h00, 1'b1)
      rd(prsg_pkg::ADDR_SW_RESET, 32'h0, OK);
      $display("soft reset test done");
      v = 16'($random(seed)) & 16'hfff7;
      wr(prsg_pkg::ADDR_RUN_EN, 32'hffff, OK);
      wr(prsg_pkg::ADDR_SLEEP_EN, {16'h0, v}, OK);
      tick(6);
      sleep <= 1'b1;
      tick(3);
      `CHK(per.clk_en, 16'hffff)
      wr(prsg_pkg::ADDR_GATE_CTL, 32'h1, OK);
      tick(3);
      `CHK(per.clk_en, v)
      pre = cnt;
      tick(5);
      `CHK(cnt, pre)
      sleep <= 1'b0;
      tick(3);
      `CHK(per.clk_en, 16'hffff)
      `CHK(cnt > pre, 1'b1)
      rd(prsg_pkg::ADDR_SLEEP_EN, {16'h0, v}, OK);
      $display("sleep test done");
      // Code 7 is refused, so the last legal ratio must survive it.
      for (int n = 0; n < 8; n++) begin
         c = (n < 7) ? n : int'(prsg_pkg::pwm_clk_div_by_sixtyfour);
         wr(prsg_pkg::ADDR_PWM_DIV, 32'(n), OK);
         rd(prsg_pkg::ADDR_PWM_DIV, 32'(c), OK);
         tick(64);
         hi = 0;
         rises = 0;
         prev = pwm;
         repeat (128) begin
            @(posedge clk);
            hi += pwm;
            rises += (pwm && !prev);
            prev = pwm;
         end
         `CHK(hi, (c == 0) ? 128 : 64)
         `CHK(rises, pwm_rises(c))
      end
      $display("divider test done");
      // A mid-run reset must bring every setting back to its reset value.
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      `CHK(per, 48'h0)
      rd(prsg_pkg::ADDR_RUN_EN, 32'h0, OK);
      rd(prsg_pkg::ADDR_PWM_DIV, 32'(prsg_pkg::PWM_DIV_RST), OK);
      $display("second reset test done");
      report_and_stop;
   end
endmodule
